// ==== inc/dsuhp_if.sv ====
/*
 * Pin level carrier between the host end and the device end.
 * Assumes both ends share one clock; resolves the shared wires here.
 */
`timescale 1ns/10ps
`default_nettype none
interface dsuhp_if;
	logic       busStyle;       // Bus style strap
	logic [2:0] registerSelect; // Register select lines
	logic [7:0] hostData;       // Host drive value
	logic       hostDataOe;     // Host drives data bus
	logic [7:0] devData;        // Device drive value
	logic       devDataOe;      // Device drives data bus
	logic       readStrobeN;    // Read strobe, active low
	logic       writeStrobeN;   // Write strobe or direction
	logic       chanASelectN;   // Channel A or device select
	logic       chanBSelectN;   // Channel B select or address bit
	logic       chanAIrqOut;    // Channel A irq drive value
	logic       chanAIrqOe;     // Channel A irq drive enable
	logic       chanBIrqOut;    // Channel B irq drive value
	logic       chanBIrqOe;     // Channel B irq drive enable
	logic [7:0] dataBus;        // Resolved data bus
	logic       chanAIrq;       // Resolved channel A irq pin
	logic       chanBIrq;       // Resolved channel B irq pin

	// Undriven data bus floats high as with pull-ups
	assign dataBus = devDataOe ? devData :
		(hostDataOe ? hostData : dsuhp_pkg::BUS_IDLE);
	// Open drain style has a pull-up; separate style floats low
	assign chanAIrq = chanAIrqOe ? chanAIrqOut :
		(busStyle == dsuhp_pkg::STYLE_RNW);
	assign chanBIrq = chanBIrqOe ? chanBIrqOut : 1'b0;

	modport device (
		input  busStyle, registerSelect, dataBus,
		input  readStrobeN, writeStrobeN, chanASelectN, chanBSelectN,
		output devData, devDataOe,
		output chanAIrqOut, chanAIrqOe, chanBIrqOut, chanBIrqOe
	);
	modport host (
		output busStyle, registerSelect, hostData, hostDataOe,
		output readStrobeN, writeStrobeN, chanASelectN, chanBSelectN,
		input  dataBus, chanAIrq, chanBIrq
	);
endinterface : dsuhp_if
`default_nettype wire

// ==== inc/dsuhp_pkg.sv ====
/*
 * Shared constants and state types for the dual style host port.
 * Assumes a single 200 MHz clock on both ends of the port.
 */
`default_nettype none
package dsuhp_pkg;
	// Clock period and host bus timing, in ns
	localparam int CLK_NS     = 5;
	localparam int SETUP_NS   = 10;
	localparam int STROBE_NS  = 20;
	localparam int RECOVER_NS = 10;
	// Least times, rounded up to whole cycles
	localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W       = 4;
	// Strap levels for the two bus styles
	localparam logic STYLE_SEP = 1'b1;
	localparam logic STYLE_RNW = 1'b0;
	// Direction line levels in read/not-write style
	localparam logic RNW_READ  = 1'b1;
	localparam logic RNW_WRITE = 1'b0;
	// Channel codes
	localparam logic CHAN_A = 1'b0;
	localparam logic CHAN_B = 1'b1;
	// Register geometry: 3 select bits, 8 bits of data
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [2:0] MCR_OFFSET = 3'h4;
	localparam int IRQ_EN_BIT = 3;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] BUS_IDLE  = 8'hff;
	// Device end states
	typedef enum logic [2:0] {
		DEV_IDLE  = 3'b001,
		DEV_READ  = 3'b010,
		DEV_WRITE = 3'b100
	} dsuhp_dev_state_t;
	// Host end states
	typedef enum logic [3:0] {
		HOST_IDLE    = 4'b0001,
		HOST_SETUP   = 4'b0010,
		HOST_STROBE  = 4'b0100,
		HOST_RECOVER = 4'b1000
	} dsuhp_host_state_t;
endpackage : dsuhp_pkg
`default_nettype wire

// ==== rtl/dsuhp_device.sv ====
/*
 * Device end of a dual channel UART host port with two bus styles,
 * holding a small register file per channel and driving irq pins.
 * Assumes all port pins are synchronous to clk.
 */
// What this block does
// [R1] Strap high: separate strobes; low: read/not-write
// [R2] Three select lines pick the channel register
// [R3] Eight bit bus, driven only during reads
// [R4] Read strobe fall drives data; rise ends
// [R5] Write strobe fall starts; rise loads data
// [R6] Read/not-write style ignores the read strobe
// [R7] Read/not-write: write pin gives direction
// [R8] Separate style: one select per channel
// [R9] Read/not-write: channel A select selects device
// [R10] Read/not-write: channel B select picks channel
// [R11] Separate style: irq gated by enable bit
// [R12] Read/not-write: shared open drain irq, low
// [R13] Read/not-write: channel B irq held zero
// [R14] Strobes count only with select held throughout
`timescale 1ns/10ps
`default_nettype none
module dsuhp_device #(
	parameter int ENTRIES = 16 // Two channels of eight registers
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	dsuhp_if.device          bus,
	input  wire logic        chanAIrqReq,
	input  wire logic        chanBIrqReq,
	output logic             wrValid,
	output logic             wrChan,
	output logic [2:0]       wrAddr,
	output logic [7:0]       wrData,
	output logic             rdValid,
	output logic             chanAAuxOutN,
	output logic             chanBAuxOutN
);
	dsuhp_pkg::dsuhp_dev_state_t state, next_state; // Cycle state
	logic       chan,    next_chan;    // Channel of this cycle
	logic [2:0] addr,    next_addr;    // Register of this cycle
	logic       prevRd,  prevWr;       // Strobe levels last cycle
	logic       prevCsA;               // Device select level last cycle
	logic [7:0] regs [ENTRIES];        // Register file
	logic [7:0] next_devData;          // Read byte to present
	logic       next_devDataOe;        // Drive enable
	logic       next_wrValid;          // Write done pulse
	logic       next_rdValid;          // Read done pulse
	logic       next_aOut, next_aOe;   // Channel A irq pin
	logic       next_bOut, next_bOe;   // Channel B irq pin
	logic       next_auxA, next_auxB;  // Aux outputs
	logic       sepStyle;              // Separate strobe style
	logic       rdFall, rdRise;        // Read strobe edges
	logic       wrFall, wrRise;        // Write strobe edges
	logic       csFall, csRise;        // Device select edges
	logic       oneSel;                // Exactly one channel selected
	logic       startRd, startWr;      // Cycle openings
	logic       startChan;             // Channel at opening
	logic       selHeld;               // Select still asserted
	logic       endStrobe;             // Closing edge of cycle
	logic       commit;                // Write lands this cycle
	logic       enA, enB;              // Irq enable bits

	// Edge and style decode, all from pins sampled on clk
	always_comb begin
		sepStyle = (bus.busStyle == dsuhp_pkg::STYLE_SEP); // [R1]
		rdFall   = prevRd & ~bus.readStrobeN;
		rdRise   = ~prevRd & bus.readStrobeN;
		wrFall   = prevWr & ~bus.writeStrobeN;
		wrRise   = ~prevWr & bus.writeStrobeN;
		csFall   = prevCsA & ~bus.chanASelectN;
		csRise   = ~prevCsA & bus.chanASelectN;
		// Both selects low is ambiguous, so no cycle opens
		oneSel   = bus.chanASelectN ^ bus.chanBSelectN; // [R8]
		if (sepStyle) begin
			startRd   = rdFall & oneSel; // [R4]
			startWr   = wrFall & oneSel; // [R5]
			startChan = ~bus.chanBSelectN; // [R8]
		end else begin
			// Read strobe is not looked at in this style
			startRd   = csFall &
				(bus.writeStrobeN == dsuhp_pkg::RNW_READ); // [R6] [R7] [R9]
			startWr   = csFall &
				(bus.writeStrobeN == dsuhp_pkg::RNW_WRITE); // [R7] [R9]
			startChan = bus.chanBSelectN; // [R10]
		end
		// Selects must stay low through the strobe
		if (!sepStyle)
			selHeld = ~bus.chanASelectN; // [R9]
		else if (chan == dsuhp_pkg::CHAN_A)
			selHeld = ~bus.chanASelectN; // [R14]
		else
			selHeld = ~bus.chanBSelectN; // [R14]
		if (!sepStyle)
			endStrobe = csRise; // [R9]
		else if (state == dsuhp_pkg::DEV_READ)
			endStrobe = rdRise; // [R4]
		else
			endStrobe = wrRise; // [R5]
		// A select lost before the strobe rise voids the write
		commit = (state == dsuhp_pkg::DEV_WRITE) & endStrobe &
			~(sepStyle & ~selHeld); // [R14]
	end

	// Cycle state machine and bus drive
	always_comb begin
		next_state     = state;
		next_chan      = chan;
		next_addr      = addr;
		next_devData   = bus.devData;
		next_devDataOe = bus.devDataOe;
		next_wrValid   = 1'b0;
		next_rdValid   = 1'b0;
		case (state)
			dsuhp_pkg::DEV_IDLE: begin
				next_devDataOe = 1'b0;
				if (startRd) begin
					next_state     = dsuhp_pkg::DEV_READ;
					next_chan      = startChan;
					next_addr      = bus.registerSelect; // [R2]
					next_devData   = regs[{startChan,
						bus.registerSelect}]; // [R2] [R4]
					next_devDataOe = 1'b1; // [R3] [R4]
				end else if (startWr) begin
					next_state = dsuhp_pkg::DEV_WRITE;
					next_chan  = startChan;
					next_addr  = bus.registerSelect; // [R2]
				end
			end
			dsuhp_pkg::DEV_READ: begin
				// Lost select or closing edge releases the bus
				if (endStrobe || (sepStyle && !selHeld)) begin
					next_state     = dsuhp_pkg::DEV_IDLE;
					next_devDataOe = 1'b0; // [R3] [R14]
					// In rnw style the select rising is the close
					next_rdValid   = endStrobe &
						(selHeld | ~sepStyle); // [R9] [R14]
				end
			end
			dsuhp_pkg::DEV_WRITE: begin
				next_devDataOe = 1'b0; // [R3]
				if (endStrobe || (sepStyle && !selHeld)) begin
					next_state   = dsuhp_pkg::DEV_IDLE;
					next_wrValid = commit; // [R5]
				end
			end
			default: begin
				next_state     = dsuhp_pkg::DEV_IDLE;
				next_devDataOe = 1'b0;
			end
		endcase
	end

	// Registers for the cycle state and the pins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state         <= dsuhp_pkg::DEV_IDLE;
			chan          <= dsuhp_pkg::CHAN_A;
			addr          <= 3'h0;
			prevRd        <= 1'b1;
			prevWr        <= 1'b1;
			prevCsA       <= 1'b1;
			bus.devData   <= dsuhp_pkg::REG_RESET;
			bus.devDataOe <= 1'b0;
			wrValid       <= 1'b0;
			wrChan        <= dsuhp_pkg::CHAN_A;
			wrAddr        <= 3'h0;
			wrData        <= dsuhp_pkg::REG_RESET;
			rdValid       <= 1'b0;
		end else begin
			state         <= next_state;
			chan          <= next_chan;
			addr          <= next_addr;
			prevRd        <= bus.readStrobeN;
			prevWr        <= bus.writeStrobeN;
			prevCsA       <= bus.chanASelectN;
			bus.devData   <= next_devData;
			bus.devDataOe <= next_devDataOe;
			wrValid       <= next_wrValid;
			rdValid       <= next_rdValid;
			if (commit) begin
				wrChan <= chan;
				wrAddr <= addr;
				wrData <= bus.dataBus;
			end
		end
	end

	// One byte register per entry, loaded on a committed write
	for (genvar e = 0; e < ENTRIES; e++) begin : gEntry
		logic [7:0] next_reg; // Next byte of this entry
		always_comb begin
			next_reg = regs[e];
			if (commit && ({chan, addr} == 4'(e)))
				next_reg = bus.dataBus; // [R5]
		end
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b)
				regs[e] <= dsuhp_pkg::REG_RESET;
			else
				regs[e] <= next_reg;
		end
	end

	// Interrupt pins; enable bits live in each modem control byte
	always_comb begin
		enA = regs[{dsuhp_pkg::CHAN_A, dsuhp_pkg::MCR_OFFSET}]
			[dsuhp_pkg::IRQ_EN_BIT];
		enB = regs[{dsuhp_pkg::CHAN_B, dsuhp_pkg::MCR_OFFSET}]
			[dsuhp_pkg::IRQ_EN_BIT];
		// Aux outputs follow the enable bits in either style
		next_auxA = ~enA; // [R11]
		next_auxB = ~enB; // [R11]
		if (sepStyle) begin
			next_aOut = chanAIrqReq; // [R11]
			next_aOe  = enA; // [R11]
			next_bOut = chanBIrqReq; // [R11]
			next_bOe  = enB; // [R11]
		end else begin
			// Only ever pulls low; the pull-up makes the high
			next_aOut = 1'b0; // [R12]
			next_aOe  = chanAIrqReq | chanBIrqReq; // [R12]
			next_bOut = 1'b0; // [R13]
			next_bOe  = 1'b1; // [R13]
		end
	end

	// Interrupt pin registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.chanAIrqOut <= 1'b0;
			bus.chanAIrqOe  <= 1'b0;
			bus.chanBIrqOut <= 1'b0;
			bus.chanBIrqOe  <= 1'b0;
			chanAAuxOutN    <= 1'b1;
			chanBAuxOutN    <= 1'b1;
		end else begin
			bus.chanAIrqOut <= next_aOut;
			bus.chanAIrqOe  <= next_aOe;
			bus.chanBIrqOut <= next_bOut;
			bus.chanBIrqOe  <= next_bOe;
			chanAAuxOutN    <= next_auxA;
			chanBAuxOutN    <= next_auxB;
		end
	end
endmodule : dsuhp_device
`default_nettype wire

// ==== rtl/dsuhp_host.sv ====
/*
 * Host end of the dual style UART port: runs one register read or
 * write per request in the strapped bus style and reports results.
 * Assumes user requests are synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module dsuhp_host (
	input  wire logic        clk,
	input  wire logic        rst_b,
	dsuhp_if.host            bus,
	input  wire logic        styleSep,
	input  wire logic        reqValid,
	input  wire logic        reqWrite,
	input  wire logic        reqChan,
	input  wire logic [2:0]  reqAddr,
	input  wire logic [7:0]  reqData,
	output logic             reqReady,
	output logic             rspValid,
	output logic [7:0]       rspData,
	output logic             irqA,
	output logic             irqB
);
	localparam int W = dsuhp_pkg::CNT_W;
	dsuhp_pkg::dsuhp_host_state_t state, next_state; // Cycle state
	logic [W-1:0] cnt,  next_cnt;  // Cycles left in phase
	logic         wr,   next_wr;   // Cycle is a write
	logic         ch,   next_ch;   // Channel of cycle
	logic [2:0]   next_addr;       // Register select
	logic [7:0]   next_data;       // Write byte
	logic         next_style;      // Strap, changed only when idle
	logic         next_rdN, next_wrN, next_csA, next_csB, next_oe;
	logic         next_rspValid;   // Read done pulse
	logic [7:0]   next_rspData;    // Read byte
	logic         act;             // Select phase of a cycle

	// Phase sequencing and pin values for the next cycle
	always_comb begin
		next_state    = state;
		next_cnt      = cnt;
		next_wr       = wr;
		next_ch       = ch;
		next_addr     = bus.registerSelect;
		next_data     = bus.hostData;
		next_style    = bus.busStyle;
		next_rspValid = 1'b0;
		next_rspData  = rspData;
		case (state)
			dsuhp_pkg::HOST_IDLE: begin
				next_style = styleSep; // [R1]
				if (reqValid) begin
					next_state = dsuhp_pkg::HOST_SETUP;
					next_cnt   = W'(dsuhp_pkg::SETUP_CYC - 1);
					next_wr    = reqWrite;
					next_ch    = reqChan;
					next_addr  = reqAddr; // [R2]
					next_data  = reqData;
				end
			end
			dsuhp_pkg::HOST_SETUP: begin
				next_cnt = cnt - W'(1);
				if (cnt == '0) begin
					next_state = dsuhp_pkg::HOST_STROBE;
					next_cnt   = W'(dsuhp_pkg::STROBE_CYC - 1);
				end
			end
			dsuhp_pkg::HOST_STROBE: begin
				next_cnt = cnt - W'(1);
				if (cnt == '0) begin
					// Sample as the strobe rises
					next_state    = dsuhp_pkg::HOST_RECOVER;
					next_cnt      = W'(dsuhp_pkg::RECOVER_CYC - 1);
					next_rspValid = ~wr; // [R4]
					next_rspData  = wr ? rspData : bus.dataBus; // [R4]
				end
			end
			dsuhp_pkg::HOST_RECOVER: begin
				next_cnt = cnt - W'(1);
				if (cnt == '0)
					next_state = dsuhp_pkg::HOST_IDLE;
			end
			default: next_state = dsuhp_pkg::HOST_IDLE;
		endcase
		// In separate style selects hold through recovery so the strobe rise counts
		act = (next_state != dsuhp_pkg::HOST_IDLE);
		next_oe = act & next_wr; // [R3]
		if (next_style == dsuhp_pkg::STYLE_SEP) begin
			next_csA = ~(act & (next_ch == dsuhp_pkg::CHAN_A)); // [R8]
			next_csB = ~(act & (next_ch == dsuhp_pkg::CHAN_B)); // [R8]
			next_rdN = ~((next_state == dsuhp_pkg::HOST_STROBE) &
				~next_wr); // [R4]
			next_wrN = ~((next_state == dsuhp_pkg::HOST_STROBE) &
				next_wr); // [R5]
		end else begin
			next_csA = ~(next_state == dsuhp_pkg::HOST_STROBE); // [R9]
			next_csB = next_ch; // [R10]
			next_rdN = 1'b1; // [R6]
			next_wrN = next_wr ? dsuhp_pkg::RNW_WRITE :
				dsuhp_pkg::RNW_READ; // [R7]
		end
	end

	// Registers; every pin and output comes from here
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state              <= dsuhp_pkg::HOST_IDLE;
			cnt                <= '0;
			wr                 <= 1'b0;
			ch                 <= dsuhp_pkg::CHAN_A;
			bus.busStyle       <= dsuhp_pkg::STYLE_SEP;
			bus.registerSelect <= 3'h0;
			bus.hostData       <= dsuhp_pkg::REG_RESET;
			bus.hostDataOe     <= 1'b0;
			bus.readStrobeN    <= 1'b1;
			bus.writeStrobeN   <= 1'b1;
			bus.chanASelectN   <= 1'b1;
			bus.chanBSelectN   <= 1'b1;
			reqReady           <= 1'b1;
			rspValid           <= 1'b0;
			rspData            <= dsuhp_pkg::REG_RESET;
			irqA               <= 1'b0;
			irqB               <= 1'b0;
		end else begin
			state              <= next_state;
			cnt                <= next_cnt;
			wr                 <= next_wr;
			ch                 <= next_ch;
			bus.busStyle       <= next_style;
			bus.registerSelect <= next_addr;
			bus.hostData       <= next_data;
			bus.hostDataOe     <= next_oe;
			bus.readStrobeN    <= next_rdN;
			bus.writeStrobeN   <= next_wrN;
			bus.chanASelectN   <= next_csA;
			bus.chanBSelectN   <= next_csB;
			reqReady <= (next_state == dsuhp_pkg::HOST_IDLE);
			rspValid           <= next_rspValid;
			rspData            <= next_rspData;
			// Shared irq is active low in read/not-write style
			irqA <= (bus.busStyle == dsuhp_pkg::STYLE_SEP) ?
				bus.chanAIrq : ~bus.chanAIrq; // [R12]
			irqB <= bus.chanBIrq; // [R11]
		end
	end
endmodule : dsuhp_host
`default_nettype wire

// ==== testbench/dsuhp_checker.sv ====
/*
 * Pin level checker for the dual style host port link.
 * Assumes it sees the interface signals joining the host and device ends.
 */
`timescale 1ns/10ps
`default_nettype none
module dsuhp_checker (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       busStyle,
	input wire logic [2:0] registerSelect,
	input wire logic       hostDataOe,
	input wire logic       devDataOe,
	input wire logic       readStrobeN,
	input wire logic       writeStrobeN,
	input wire logic       chanASelectN,
	input wire logic       chanBSelectN,
	input wire logic       chanAIrqOut,
	input wire logic       chanAIrqOe,
	input wire logic       chanBIrqOut,
	input wire logic       chanBIrqOe
);
	// All checks share the port clock and its reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Two drivers on the data bus would corrupt both directions
	bus_no_fight_a: assert property (!(devDataOe && hostDataOe))
		else $error("both ends drive the data bus");
	// Device drives only for a read strobe in separate style
	read_drive_a: assert property ($rose(devDataOe) && busStyle
		|-> !readStrobeN && writeStrobeN)
		else $error("data driven without a read strobe");
	// Drive ends on the edge after the strobe is seen high
	drive_stop_a: assert property (devDataOe && busStyle && readStrobeN
		|=> !devDataOe)
		else $error("data drive outlived the read strobe");
	// Exactly one channel select may open a cycle
	sep_one_sel_a: assert property ($rose(devDataOe) && busStyle
		|-> chanASelectN != chanBSelectN)
		else $error("drive without exactly one select");
	// Read/not-write: device select low and direction read
	rnw_dev_sel_a: assert property ($rose(devDataOe) && !busStyle
		|-> !chanASelectN && writeStrobeN)
		else $error("drive without device select and read");
	// Slack of three samples covers the registered style follow
	rnw_b_low_a: assert property (!busStyle [*3]
		|-> chanBIrqOe && !chanBIrqOut)
		else $error("channel B irq not held low");
	// Shared irq is open drain: never drives high
	open_drain_a: assert property (!busStyle [*3]
		|-> !(chanAIrqOe && chanAIrqOut))
		else $error("shared irq driven high");
	// Host strobe lasts exactly four cycles
	strobe_width_a: assert property ($fell(readStrobeN)
		|-> !readStrobeN [*4] ##1 readStrobeN)
		else $error("read strobe width wrong");
	// Register select must not move while the device drives
	sel_stable_a: assert property (devDataOe && $past(devDataOe)
		|-> $stable(registerSelect))
		else $error("register select moved during a read");

	// Main scenarios reached
	sep_read_c: cover property ($rose(devDataOe) && busStyle);
	rnw_read_c: cover property ($rose(devDataOe) && !busStyle);
	irq_drive_c: cover property (busStyle && chanAIrqOe);
endmodule : dsuhp_checker
`default_nettype wire

// ==== testbench/tb.sv ====
/*
 * Self-checking bench: host end and device end joined by one link,
 * plus a second device whose pins the bench drives, rules bent.
 * Assumes the device and host modules and the link interface.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic       clk = 1'b0;         // 200 MHz clock
	logic       rst_b = 1'b0;       // Reset, active low
	logic       styleSep = 1'b1;    // Strap request to host
	logic       reqValid = 1'b0;    // Host user request
	logic       reqWrite = 1'b0;
	logic       reqChan = 1'b0;
	logic [2:0] reqAddr = 3'h0;
	logic [7:0] reqData = 8'h00;
	logic       reqReady, rspValid, irqA, irqB;
	logic [7:0] rspData;
	logic       chanAIrqReq = 1'b0; // Device interrupt requests
	logic       chanBIrqReq = 1'b0;
	logic       wrValid, wrChan, rdValid, chanAAuxOutN, chanBAuxOutN;
	logic [2:0] wrAddr;
	logic [7:0] wrData, wrData2, got;
	logic       wrValid2, wrChan2;  // Bench driven device results
	int         fail_count = 0;
	int         n_compared = 0;
	int         wrCount = 0;        // Commits seen on each device
	int         wrCount2 = 0;
	int         rdCount = 0;        // Read completions seen

	dsuhp_if link ();
	dsuhp_if pins ();
	dsuhp_host dsuhp_host_i (.clk, .rst_b, .bus(link), .styleSep,
		.reqValid, .reqWrite, .reqChan, .reqAddr, .reqData, .reqReady,
		.rspValid, .rspData, .irqA, .irqB);
	dsuhp_device dsuhp_device_i (.clk, .rst_b, .bus(link), .chanAIrqReq,
		.chanBIrqReq, .wrValid, .wrChan, .wrAddr, .wrData, .rdValid,
		.chanAAuxOutN, .chanBAuxOutN);
	// Second device sees only bench stimulus, so faults can be made
	dsuhp_device dsuhp_device_i2 (.clk, .rst_b, .bus(pins),
		.chanAIrqReq(1'b0), .chanBIrqReq(1'b0), .wrValid(wrValid2),
		.wrChan(wrChan2), .wrAddr(), .wrData(wrData2), .rdValid(),
		.chanAAuxOutN(), .chanBAuxOutN());
	dsuhp_checker dsuhp_checker_i (.clk, .rst_b,
		.busStyle(link.busStyle), .registerSelect(link.registerSelect),
		.hostDataOe(link.hostDataOe), .devDataOe(link.devDataOe),
		.readStrobeN(link.readStrobeN), .writeStrobeN(link.writeStrobeN),
		.chanASelectN(link.chanASelectN), .chanBSelectN(link.chanBSelectN),
		.chanAIrqOut(link.chanAIrqOut), .chanAIrqOe(link.chanAIrqOe),
		.chanBIrqOut(link.chanBIrqOut), .chanBIrqOe(link.chanBIrqOe));

	// Free running clock, 5 ns period
	always #2.5 clk = ~clk;

	// Count commit and read pulses; all are one cycle wide
	always @(posedge clk) begin
		if (wrValid === 1'b1) wrCount++;
		if (wrValid2 === 1'b1) wrCount2++;
		if (rdValid === 1'b1) rdCount++;
	end

	// Compare one value and report a mismatch
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Counts, verdict and end of run
	task tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// One host request; read data lands in got, bounded waits
	task host_op(input logic wr, input logic ch, input logic [2:0] ad,
		input logic [7:0] dt);
		int n;
		got = 8'hxx;
		@(negedge clk);
		reqValid = 1'b1;
		reqWrite = wr;
		reqChan = ch;
		reqAddr = ad;
		reqData = dt;
		@(negedge clk);
		reqValid = 1'b0;
		@(negedge clk);
		for (n = 0; n < 20 && reqReady !== 1'b1; n++) begin
			if (rspValid === 1'b1) got = rspData;
			@(negedge clk);
		end
		if (n == 20) begin
			fail_count++;
			tally_and_finish;
		end
	endtask : host_op

	// Write cycle on the bench driven pins; selects may be wrong or lost
	task pin_write(input logic sty, input logic a, input logic b,
		input logic rdn, input logic lose, input logic [7:0] dt);
		@(negedge clk);
		pins.busStyle = sty;
		pins.registerSelect = 3'h5;
		pins.hostData = dt;
		pins.hostDataOe = 1'b1;
		pins.readStrobeN = rdn;
		pins.writeStrobeN = sty; // Direction write in rnw style
		pins.chanASelectN = sty ? a : 1'b1;
		pins.chanBSelectN = b;
		repeat (2) @(negedge clk);
		if (sty) pins.writeStrobeN = 1'b0;
		else pins.chanASelectN = 1'b0;
		repeat (4) @(negedge clk);
		if (sty) pins.writeStrobeN = 1'b1;
		if (!sty || lose) pins.chanASelectN = 1'b1;
		if (lose) pins.chanBSelectN = 1'b1;
		repeat (3) @(negedge clk);
		pins.writeStrobeN = 1'b1;
		pins.chanASelectN = 1'b1;
		pins.chanBSelectN = 1'b1;
		pins.hostDataOe = 1'b0;
		pins.readStrobeN = 1'b1;
		repeat (2) @(negedge clk);
	endtask : pin_write

	// Main sequence
	initial begin
		int s, c, a, nw, nr;
		pins.busStyle = 1'b1;
		pins.registerSelect = 3'h0;
		pins.hostData = 8'h00;
		pins.hostDataOe = 1'b0;
		pins.readStrobeN = 1'b1;
		pins.writeStrobeN = 1'b1;
		pins.chanASelectN = 1'b1;
		pins.chanBSelectN = 1'b1;
		nw = 0;
		nr = 0;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		// Every register of both channels, separate then rnw style
		for (s = 1; s >= 0; s--) begin
			styleSep = s[0];
			for (c = 0; c < 2; c++) begin
				for (a = 0; a < 8; a++) begin
					host_op(1'b1, c[0], a[2:0], {s[0], 3'h3, c[0], a[2:0]});
					nw++;
					check(wrData, {s[0], 3'h3, c[0], a[2:0]});
					check({4'h0, wrChan, wrAddr}, {4'h0, c[0], a[2:0]});
					check(wrCount[7:0], nw[7:0]);
				end
			end
			for (c = 0; c < 2; c++) begin
				for (a = 0; a < 8; a++) begin
					host_op(1'b0, c[0], a[2:0], 8'h00);
					nr++;
					check(got, {s[0], 3'h3, c[0], a[2:0]});
					check(rdCount[7:0], nr[7:0]);
				end
			end
		end
		// Separate style irqs gated by the enable bit
		styleSep = 1'b1;
		chanAIrqReq = 1'b1;
		chanBIrqReq = 1'b1;
		host_op(1'b1, 1'b0, dsuhp_pkg::MCR_OFFSET, 8'h00);
		host_op(1'b1, 1'b1, dsuhp_pkg::MCR_OFFSET, 8'h08);
		repeat (3) @(negedge clk);
		check({6'h0, irqA, chanAAuxOutN}, 8'h01);
		check({6'h0, irqB, chanBAuxOutN}, 8'h02);
		host_op(1'b1, 1'b0, dsuhp_pkg::MCR_OFFSET, 8'h08);
		repeat (3) @(negedge clk);
		check({6'h0, irqA, chanAAuxOutN}, 8'h02);
		chanAIrqReq = 1'b0;
		repeat (3) @(negedge clk);
		check({6'h0, irqA, chanAAuxOutN}, 8'h00);
		// Read/not-write: channel B request on the shared irq
		styleSep = 1'b0;
		repeat (6) @(negedge clk);
		check({6'h0, irqA, irqB}, 8'h02);
		check({7'h0, link.chanBIrqOe}, 8'h01);
		chanBIrqReq = 1'b0;
		repeat (3) @(negedge clk);
		check({6'h0, irqA, irqB}, 8'h00);
		// Bench driven pins: one good write, then refused ones
		pin_write(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'ha5);
		check(wrCount2[7:0], 8'h01);
		check({wrData2[6:0], wrChan2}, {7'h25, 1'b0});
		pin_write(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h11);
		pin_write(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h22);
		pin_write(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h33);
		check(wrCount2[7:0], 8'h01);
		// Rnw write to channel B with the read strobe held low
		pin_write(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h5c);
		check(wrCount2[7:0], 8'h02);
		check({wrData2[6:0], wrChan2}, {7'h5c, 1'b1});
		tally_and_finish;
	end
endmodule : tb
`default_nettype wire
